/* core/scms_pkg.sv */
// Shared constants and types of the clock and mode select block.
// Assumes a 100 MHz APB clock; PLL and clock mux sit outside.
package scms_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] SCMS_OFF_CLK_BUF  = 8'h00;
  localparam logic [7:0] SCMS_OFF_MODE_BUF = 8'h04;
  localparam logic [7:0] SCMS_OFF_CMD      = 8'h08;
  localparam logic [7:0] SCMS_OFF_STATUS   = 8'h0c;
  localparam logic [7:0] SCMS_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] SCMS_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] SCMS_OFF_CLK_ACT  = 8'h18;
  localparam logic [7:0] SCMS_OFF_MODE_ACT = 8'h1c;

  // Command register bits
  localparam int SCMS_CMD_XFER_BIT   = 0;
  localparam int SCMS_CMD_PLLRST_BIT = 1;

  // Status register fields
  localparam int SCMS_ST_LOCK_BIT = 0;
  localparam int SCMS_ST_SRC_POS  = 1;
  localparam int SCMS_ST_MODE_POS = 3;

  // Interrupt status bits
  localparam int SCMS_EV_LOCKED = 0;
  localparam int SCMS_EV_UNLOCK = 1;
  localparam int SCMS_EV_XFER   = 2;
  localparam int SCMS_EV_W      = 3;

  //////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int SCMS_CLK_PERIOD_NS = 10;
  localparam int SCMS_PLL_RST_NS    = 100;
  localparam int SCMS_PLL_RST_CYC   =
    (SCMS_PLL_RST_NS + SCMS_CLK_PERIOD_NS - 1) / SCMS_CLK_PERIOD_NS;
  localparam int SCMS_RST_CNT_W     = 8;

  // Multiplier field holds factor minus one
  localparam logic [4:0] SCMS_MULT_M1_RST = 5'h09;

  //////////////////////////////////////////////////////////////////////////
  // Clock setup, LSB first: auto_clr at bit 0 ... pll_en at bit 13
  typedef struct packed {
    logic       pll_en;
    logic [1:0] in_cfg;
    logic [4:0] mult_m1;
    logic       dbl;
    logic       in_div2;
    logic       out_div2;
    logic       low_range;
    logic       gate_lock;
    logic       auto_clr;
  } scms_clk_cfg_t;

  localparam int SCMS_CLK_W = $bits(scms_clk_cfg_t);
  localparam scms_clk_cfg_t SCMS_CLK_RST = '{
    pll_en: 1'b0, in_cfg: 2'h0, mult_m1: SCMS_MULT_M1_RST,
    dbl: 1'b0, in_div2: 1'b0, out_div2: 1'b0, low_range: 1'b0,
    gate_lock: 1'b0, auto_clr: 1'b0};

  // Mode enables: bit 0 direct switch, bit 1 modulus, bit 2 ramp
  typedef struct packed {
    logic ramp_en;
    logic mod_en;
    logic ds_en;
  } scms_mode_cfg_t;

  localparam int SCMS_MODE_W = $bits(scms_mode_cfg_t);

  typedef enum logic [1:0] {
    SCMS_SRC_REF = 2'b00,
    SCMS_SRC_PLL = 2'b01,
    SCMS_SRC_OFF = 2'b10
  } scms_src_t;

  typedef enum logic [1:0] {
    SCMS_MODE_SINGLE = 2'b00,
    SCMS_MODE_DIRECT = 2'b01,
    SCMS_MODE_MOD    = 2'b10,
    SCMS_MODE_RAMP   = 2'b11
  } scms_mode_t;

  // PLL control bundle sent to the analogue PLL
  typedef struct packed {
    logic       enable;
    logic [1:0] in_cfg;
    logic [5:0] factor;
    logic       dbl;
    logic       in_div2;
    logic       out_div2;
    logic       low_range;
  } scms_pll_ctl_t;

endpackage

/* core/scms_clock_mode_select.sv */
// Clock source, PLL setup and operating mode select with buffered commit.
// Assumes an APB master on pclk and a PLL lock level from another domain.
//
// Operation
// - Settings wait in a buffer and go active only on a transfer strobe or a transfer command bit write.
// - PLL disabled, the default, routes the reference straight to the core.
// - PLL factor is selectable from 1 to 32, reset value 10.
// - Doubler bit adds a times-two step on the reference path.
// - Input divider bit halves the signal entering the PLL.
// - Output divider bit halves the signal leaving the PLL.
// - Multiplier, doubler and dividers act only with the PLL enabled.
// - PLL reset restarts the PLL; lock must be reacquired afterwards.
// - Lock status shown; locked runs from PLL, unlocked from reference, or no clock with lock gating set.
// - With PLL selected and lock gating clear, reference clocks the core until lock.
// - With lock gating set, no system clock until lock.
// - No mode enable set gives single tone mode, the default.
// - Direct switch enable wins over all other mode enables.
// - Modulus mode needs modulus enable set and direct switch clear.
// - Ramp mode needs ramp enable with direct switch and modulus clear.
// - Auto-clear clears the phase accumulator one cycle on transfer.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module scms_clock_mode_select
  import scms_pkg::*;
#(
  parameter int RST_CYC = SCMS_PLL_RST_CYC
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          register_transfer_strobe,
  input  wire logic          pll_lock_in,
  output scms_pll_ctl_t      pll_ctl,
  output logic               pll_rst,
  output scms_src_t          sys_clk_src,
  output scms_mode_t         op_mode,
  output logic               pll_locked,
  output logic               acc_clear,
  output logic               irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    scms_clk_cfg_t               clk_buf;
    scms_mode_cfg_t              mode_buf;
    scms_clk_cfg_t               clk_act;
    scms_mode_cfg_t              mode_act;
    logic                        lock_s1;
    logic                        lock_s2;
    logic                        strb_s1;
    logic                        strb_s2;
    logic                        strb_prev;
    logic [SCMS_RST_CNT_W-1:0]   rst_cnt;
    logic                        locked;
    logic                        relock_wait;
    logic                        acc_clr;
    logic [SCMS_EV_W-1:0]        irq_stat;
    logic [SCMS_EV_W-1:0]        irq_mask;
    logic [31:0]                 rdata;
    scms_src_t                   src;
    scms_mode_t                  mode;
    scms_pll_ctl_t               pll;
  } scms_state_t;

  localparam scms_pll_ctl_t PLL_OFF = '0;

  localparam scms_state_t ST_RST = '{
    clk_buf:   SCMS_CLK_RST,
    mode_buf:  '0,
    clk_act:   SCMS_CLK_RST,
    mode_act:  '0,
    lock_s1:   1'b0,
    lock_s2:   1'b0,
    strb_s1:   1'b0,
    strb_s2:   1'b0,
    strb_prev: 1'b0,
    rst_cnt:   '0,
    locked:    1'b0,
    relock_wait: 1'b0,
    acc_clr:   1'b0,
    irq_stat:  '0,
    irq_mask:  '0,
    rdata:     '0,
    src:       SCMS_SRC_REF,
    mode:      SCMS_MODE_SINGLE,
    pll:       PLL_OFF
  };

  localparam logic [SCMS_RST_CNT_W-1:0] RST_LOAD =
    SCMS_RST_CNT_W'(RST_CYC);

  scms_state_t s_q;
  scms_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode helpers

  logic       wr_en;
  logic       rd_en;
  logic       hit;
  logic       xfer;
  logic       rst_req;
  logic       lock_now;
  logic [SCMS_EV_W-1:0] ev;
  logic [31:0] rd_val;

  assign wr_en = psel && penable && pwrite;
  // Read setup cycle; data is latched for the access phase
  assign rd_en = psel && !penable && !pwrite;

  always_comb begin
    hit    = 1'b1;
    rd_val = '0;
    if (paddr == SCMS_OFF_CLK_BUF) begin
      rd_val[SCMS_CLK_W-1:0] = s_q.clk_buf;
    end else if (paddr == SCMS_OFF_MODE_BUF) begin
      rd_val[SCMS_MODE_W-1:0] = s_q.mode_buf;
    end else if (paddr == SCMS_OFF_CMD) begin
      rd_val = '0;
    end else if (paddr == SCMS_OFF_STATUS) begin
      rd_val[SCMS_ST_LOCK_BIT]              = s_q.locked;
      rd_val[SCMS_ST_SRC_POS +: 2]          = s_q.src;
      rd_val[SCMS_ST_MODE_POS +: 2]         = s_q.mode;
    end else if (paddr == SCMS_OFF_IRQ_STAT) begin
      rd_val[SCMS_EV_W-1:0] = s_q.irq_stat;
    end else if (paddr == SCMS_OFF_IRQ_MASK) begin
      rd_val[SCMS_EV_W-1:0] = s_q.irq_mask;
    end else if (paddr == SCMS_OFF_CLK_ACT) begin
      rd_val[SCMS_CLK_W-1:0] = s_q.clk_act;
    end else if (paddr == SCMS_OFF_MODE_ACT) begin
      rd_val[SCMS_MODE_W-1:0] = s_q.mode_act;
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;

    // Pin synchronisers; first stage feeds only the second
    s_d.lock_s1   = pll_lock_in;
    s_d.lock_s2   = s_q.lock_s1;
    s_d.strb_s1   = register_transfer_strobe;
    s_d.strb_s2   = s_q.strb_s1;
    s_d.strb_prev = s_q.strb_s2;

    // Buffer writes
    if (wr_en && paddr == SCMS_OFF_CLK_BUF) begin
      s_d.clk_buf = pwdata[SCMS_CLK_W-1:0];
    end
    if (wr_en && paddr == SCMS_OFF_MODE_BUF) begin
      s_d.mode_buf = pwdata[SCMS_MODE_W-1:0];
    end
    if (wr_en && paddr == SCMS_OFF_IRQ_MASK) begin
      s_d.irq_mask = pwdata[SCMS_EV_W-1:0];
    end

    xfer = (s_q.strb_s2 && !s_q.strb_prev) ||
           (wr_en && paddr == SCMS_OFF_CMD && pwdata[SCMS_CMD_XFER_BIT]);
    if (xfer) begin
      s_d.clk_act  = s_q.clk_buf;
      s_d.mode_act = s_q.mode_buf;
    end

    s_d.acc_clr = xfer && s_q.clk_buf.auto_clr;

    // PLL reset pulse and lock drop
    rst_req = wr_en && paddr == SCMS_OFF_CMD &&
              pwdata[SCMS_CMD_PLLRST_BIT];
    if (rst_req) begin
      s_d.rst_cnt = RST_LOAD;
    end else if (s_q.rst_cnt != '0) begin
      s_d.rst_cnt = s_q.rst_cnt - 1'b1;
    end

    // Old lock level still in synchroniser
    // Hold off until the pin is seen low after a restart
    if (rst_req) begin
      s_d.relock_wait = 1'b1;
    end else if (!s_q.lock_s2) begin
      s_d.relock_wait = 1'b0;
    end

    lock_now = s_q.lock_s2 && (s_q.rst_cnt == '0) && !rst_req &&
               !s_q.relock_wait && s_q.clk_act.pll_en;
    s_d.locked = lock_now;

    // Events; set wins over write-one-to-clear
    ev = '0;
    ev[SCMS_EV_LOCKED] = lock_now && !s_q.locked;
    ev[SCMS_EV_UNLOCK] = !lock_now && s_q.locked;
    ev[SCMS_EV_XFER]   = xfer;
    if (wr_en && paddr == SCMS_OFF_IRQ_STAT) begin
      s_d.irq_stat = (s_q.irq_stat & ~pwdata[SCMS_EV_W-1:0]) | ev;
    end else begin
      s_d.irq_stat = s_q.irq_stat | ev;
    end

    // Outputs follow only the active copies
    if (!s_q.clk_act.pll_en) begin
      s_d.src = SCMS_SRC_REF;
    end else if (s_q.locked) begin
      s_d.src = SCMS_SRC_PLL;
    end else if (s_q.clk_act.gate_lock) begin
      s_d.src = SCMS_SRC_OFF;
    end else begin
      s_d.src = SCMS_SRC_REF;
    end

    // PLL setup only with PLL enabled; in_cfg passes through either way
    if (s_q.clk_act.pll_en) begin
      s_d.pll.enable    = 1'b1;
      s_d.pll.in_cfg    = s_q.clk_act.in_cfg;
      s_d.pll.factor    = {1'b0, s_q.clk_act.mult_m1} + 6'h01;
      s_d.pll.dbl       = s_q.clk_act.dbl;
      s_d.pll.in_div2   = s_q.clk_act.in_div2;
      s_d.pll.out_div2  = s_q.clk_act.out_div2;
      s_d.pll.low_range = s_q.clk_act.low_range;
    end else begin
      s_d.pll        = PLL_OFF;
      s_d.pll.in_cfg = s_q.clk_act.in_cfg;
    end

    if (s_q.mode_act.ds_en) begin
      s_d.mode = SCMS_MODE_DIRECT;
    end else if (s_q.mode_act.mod_en) begin
      s_d.mode = SCMS_MODE_MOD;
    end else if (s_q.mode_act.ramp_en) begin
      s_d.mode = SCMS_MODE_RAMP;
    end else begin
      s_d.mode = SCMS_MODE_SINGLE;
    end

    // Read data captured in setup, shown in access
    if (rd_en) begin
      s_d.rdata = rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero wait states; read data comes from a flip-flop
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !hit;
  assign prdata      = s_q.rdata;
  assign pll_ctl     = s_q.pll;
  assign pll_rst     = s_q.rst_cnt != '0;
  assign sys_clk_src = s_q.src;
  assign op_mode     = s_q.mode;
  assign pll_locked  = s_q.locked;
  assign acc_clear   = s_q.acc_clr;
  assign irq         = |(s_q.irq_stat & s_q.irq_mask);

endmodule

`default_nettype wire

/* testbench/scms_chk.sv */
// Port checker of the clock and mode select block.
// Assumes a bind onto the top module ports.
`timescale 1ns/100ps
`default_nettype none
module scms_chk
  import scms_pkg::*;
#(parameter int RST_CYC = SCMS_PLL_RST_CYC) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic [7:0]    paddr,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          pll_lock_in,
  input wire scms_pll_ctl_t pll_ctl,
  input wire logic          pll_rst,
  input wire scms_src_t     sys_clk_src,
  input wire logic          pll_locked,
  input wire logic          acc_clear
);
  logic [7:0] rcnt_q;

  // Counts cycles of PLL reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) rcnt_q <= 8'h00;
    else rcnt_q <= pll_rst ? rcnt_q + 8'h01 : 8'h00;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  //////////////////////////////////////////////////////////////////////////
  AST_PREADY: assert property (pready)
    else $error("pready low");
  AST_SLVERR: assert property (psel && penable &&
    (paddr > 8'h1c || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  AST_ACLR_ONE: assert property (acc_clear |=> !acc_clear)
    else $error("clear pulse too long");
  AST_RST_LEN: assert property ($fell(pll_rst) |-> rcnt_q == RST_CYC)
    else $error("pll reset length wrong");
  AST_RST_UNLOCK: assert property (pll_rst |-> !pll_locked)
    else $error("locked during pll reset");
  AST_RELOCK: assert property ($fell(pll_rst) |-> (!pll_locked)[*3])
    else $error("lock shown before relock");
  AST_UNLOCK_PIN: assert property ((!pll_lock_in)[*5] |-> !pll_locked)
    else $error("locked without lock pin");
  AST_SRC_PLL: assert property (sys_clk_src == SCMS_SRC_PLL |->
    $past(pll_locked)) else $error("pll source without lock");
  AST_SRC_OFF: assert property (sys_clk_src == SCMS_SRC_OFF |->
    !$past(pll_locked)) else $error("clock gated while locked");
  AST_PLL_OFF: assert property (!pll_ctl.enable |->
    pll_ctl.factor == 6'h00 && !pll_ctl.dbl && !pll_ctl.out_div2)
    else $error("pll setup leaks while disabled");
  AST_FACTOR: assert property (pll_ctl.enable |->
    pll_ctl.factor inside {[6'h01:6'h20]}) else $error("factor range");
endmodule
`default_nettype wire

/* testbench/scms_pll_model.sv */
// Behavioural PLL that locks a fixed time after enable.
// Assumes enable and reset come from the block's PLL controls.
`timescale 1ns/100ps
`default_nettype none
module scms_pll_model #(parameter int LOCK_CYC = 20) (
  input wire logic  pclk,
  input wire logic  presetn,
  input wire logic  enable,
  input wire logic  rst,
  input wire logic  lose,
  output logic      lock
);
  logic [7:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt_q <= 8'h00;
    else if (!enable || rst || lose) cnt_q <= 8'h00;
    else if (cnt_q < LOCK_CYC) cnt_q <= cnt_q + 8'h01;
  assign lock = cnt_q == LOCK_CYC;
endmodule
`default_nettype wire

/* testbench/test_synth_clock_and_mode_select.sv */
// Self-checking bench of the clock and mode select block.
// Assumes the package, the PLL model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin \
  $display("unexpected %s exp %h got %h", n, e, s); num_errors++; end end
module test_synth_clock_and_mode_select
  import scms_pkg::*;
;
  logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic          register_transfer_strobe = 0, lose = 0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0, rd, prdata, seed = 32'h000091a0;
  logic          pready, pslverr, pll_rst, pll_locked, acc_clear, irq, err;
  logic          aclr;
  logic          pll_lock_in;
  scms_pll_ctl_t pll_ctl;
  scms_src_t     sys_clk_src;
  scms_mode_t    op_mode, pm;
  scms_clk_cfg_t cfg;
  int            num_errors = 0, compares = 0;

  scms_clock_mode_select #(.RST_CYC(2)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .register_transfer_strobe, .pll_lock_in, .pll_ctl, .pll_rst,
    .sys_clk_src, .op_mode, .pll_locked, .acc_clear, .irq);
  scms_pll_model u_pll (.pclk, .presetn, .enable(pll_ctl.enable),
    .rst(pll_rst), .lose, .lock(pll_lock_in));

  initial forever #5 pclk = ~pclk;
  initial begin
    #100us;
    num_errors++;
    end_of_test();
  end

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic scms_mode_t exp_mode(logic [2:0] m);
    if (m[0]) return SCMS_MODE_DIRECT;
    if (m[1]) return SCMS_MODE_MOD;
    if (m[2]) return SCMS_MODE_RAMP;
    return SCMS_MODE_SINGLE;
  endfunction
  function automatic scms_pll_ctl_t exp_ctl(scms_clk_cfg_t c);
    exp_ctl = '0;
    exp_ctl.in_cfg = c.in_cfg;
    if (c.pll_en) exp_ctl = '{1'b1, c.in_cfg, {1'b0, c.mult_m1} + 6'h01,
      c.dbl, c.in_div2, c.out_div2, c.low_range};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic commit();
    apb(1'b1, SCMS_OFF_CMD, 32'h1);
    #1;
    aclr = acc_clear;
    @(posedge pclk);
    #1;
  endtask
  task automatic pin();
    @(posedge pclk);
    register_transfer_strobe <= 1'b1;
    repeat (3) @(posedge pclk);
    register_transfer_strobe <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
  endtask
  task automatic wr_cfg();
    apb(1'b1, SCMS_OFF_CLK_BUF, 32'(cfg));
  endtask
  task automatic wait_lock(input logic v);
    for (int i = 0; i < 300 && pll_locked !== v; i++) @(posedge pclk);
    #1;
    `CHK("locked", v, pll_locked)
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SCMS_OFF_CLK_BUF, 32'h0);
    `CHK("clk_buf", 32'(SCMS_CLK_RST), rd)
    `CHK("src", SCMS_SRC_REF, sys_clk_src)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("slverr", 1'b1, err)
    pm = SCMS_MODE_SINGLE;
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, SCMS_OFF_MODE_BUF, 32'(m));
      `CHK("held", pm, op_mode)
      if (m[0]) pin();
      else commit();
      pm = exp_mode(3'(m));
      `CHK("mode", pm, op_mode)
    end
    for (int k = 0; k < 3; k++) begin
      cfg = scms_clk_cfg_t'(SCMS_CLK_W'(xs()));
      cfg.pll_en = 1'b0;
      cfg.gate_lock = 1'b0;
      cfg.auto_clr = ~k[0];
      wr_cfg();
      commit();
      `CHK("ctl_off", exp_ctl(cfg), pll_ctl)
      `CHK("src_off", SCMS_SRC_REF, sys_clk_src)
      cfg.pll_en = 1'b1;
      if (k < 2) cfg.mult_m1 = k ? 5'h1f : 5'h00;
      wr_cfg();
      `CHK("ctl_held", 1'b0, pll_ctl.enable)
      commit();
      `CHK("ctl_on", exp_ctl(cfg), pll_ctl)
      `CHK("aclr", cfg.auto_clr, aclr)
      `CHK("src_wait", SCMS_SRC_REF, sys_clk_src)
      wait_lock(1'b1);
      @(posedge pclk);
      #1;
      `CHK("src_pll", SCMS_SRC_PLL, sys_clk_src)
      apb(1'b1, SCMS_OFF_CMD, 32'h2);
      wait_lock(1'b0);
      wait_lock(1'b1);
    end
    cfg.gate_lock = 1'b1;
    wr_cfg();
    commit();
    lose <= 1'b1;
    wait_lock(1'b0);
    @(posedge pclk);
    #1;
    `CHK("src_gate", SCMS_SRC_OFF, sys_clk_src)
    cfg.gate_lock = 1'b0;
    wr_cfg();
    commit();
    `CHK("src_ref", SCMS_SRC_REF, sys_clk_src)
    apb(1'b1, SCMS_OFF_IRQ_STAT, 32'h7);
    apb(1'b1, SCMS_OFF_IRQ_MASK, 32'h4);
    #1;
    `CHK("irq_idle", 1'b0, irq)
    commit();
    `CHK("irq_set", 1'b1, irq)
    apb(1'b1, SCMS_OFF_IRQ_MASK, 32'h3);
    @(posedge pclk);
    #1;
    `CHK("irq_mask", 1'b0, irq)
    apb(1'b1, SCMS_OFF_IRQ_MASK, 32'h4);
    apb(1'b1, SCMS_OFF_IRQ_STAT, 32'h4);
    @(posedge pclk);
    #1;
    `CHK("irq_clr", 1'b0, irq)
    end_of_test();
  end
endmodule
bind scms_clock_mode_select scms_chk #(.RST_CYC(RST_CYC)) u_chk (.pclk,
  .presetn, .psel, .penable, .paddr, .pready, .pslverr, .pll_lock_in,
  .pll_ctl, .pll_rst, .sys_clk_src, .pll_locked, .acc_clear);
`default_nettype wire
